/* hdl/ufmc_consts.svh */
// register offsets, field positions and reset values of the policy bank
`ifndef UFMC_CONSTS_SVH
`define UFMC_CONSTS_SVH

`define UFMC_ADDR_W          12
`define UFMC_OFS_UCAST       12'h320
`define UFMC_OFS_MCAST       12'h324
`define UFMC_OFS_VLAN        12'h328
`define UFMC_OFS_MAC0        12'h330
`define UFMC_OFS_MAC1        12'h334
`define UFMC_OFS_STATUS      12'h338

`define UFMC_FWD_EN_BIT      31
`define UFMC_FWD_MASK_HI     2

`define UFMC_MAC0_ALT_BO     7
`define UFMC_MAC0_LEN_CHK    3
`define UFMC_MAC0_FC_DROP    1
`define UFMC_MAC0_AGGR_BO    0
`define UFMC_MAC0_RESET      8'h0E

`define UFMC_MAC1_NO_XCOL    3
`define UFMC_MAC1_RESET      8'h00

`define UFMC_LEN_LIMIT       16'h05DC
`define UFMC_FC_TYPE         16'h8808
`define UFMC_FC_DA           48'h0180C2000001
`define UFMC_XCOL_LIMIT      5'h10

`endif

/* hdl/ufmc_pkg.sv */
// types shared by the unknown-forward and mac policy bank
package ufmc_pkg;

  typedef enum logic [3:0] {
    UFMC_CLS_NONE  = 4'b0001,
    UFMC_CLS_VID   = 4'b0010,
    UFMC_CLS_UCAST = 4'b0100,
    UFMC_CLS_MCAST = 4'b1000
  } ufmc_cls_t;

  typedef struct packed {
    logic valid;
    logic unk_vid;
    logic unk_ucast;
    logic unk_mcast;
  } ufmc_fwd_req_t;

  typedef struct packed {
    logic      valid;
    ufmc_cls_t cls;
    logic [2:0] ports;
  } ufmc_fwd_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] type_len;
    logic [47:0] dest;
    logic [15:0] length;
  } ufmc_rx_req_t;

  typedef struct packed {
    logic valid;
    logic drop_len;
    logic drop_fc;
  } ufmc_rx_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] count;
  } ufmc_coll_t;

endpackage

/* hdl/ufmc_policy.sv */
// policy register bank with forward, receive filter and back-off decisions
`timescale 1ns/100ps
`default_nettype none
`include "ufmc_consts.svh"


module ufmc_policy
  import ufmc_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  // register port
  input  wire logic [`UFMC_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [31:0]             rdata,
  // forwarding decision
  input  wire ufmc_fwd_req_t           fwd_req,
  output ufmc_fwd_rsp_t                fwd_rsp,
  // receive filter
  input  wire ufmc_rx_req_t            rx_req,
  output ufmc_rx_rsp_t                 rx_rsp,
  // half-duplex mac steering
  input  wire logic [2:0]              half_duplex,
  input  wire ufmc_coll_t              coll,
  output logic      [2:0]              alt_backoff,
  output logic      [2:0]              aggr_backoff,
  output logic                         coll_drop
);

  logic       uc_en;
  logic [2:0] uc_mask;
  logic       mc_en;
  logic [2:0] mc_mask;
  logic       vl_en;
  logic [2:0] vl_mask;
  logic [7:0] mac0;
  logic [7:0] mac1;
  logic [31:0] next_rdata;
  ufmc_fwd_rsp_t next_fwd;
  logic        fc_type;
  logic        fc_da;

  function automatic logic [2:0] gate_mask(input logic en,
                                           input logic [2:0] m);
    gate_mask = en ? m : 3'h0;
  endfunction

  function automatic logic [31:0] fwd_word(input logic en,
                                           input logic [2:0] m);
    fwd_word = {en, 28'h0000000, m};
  endfunction

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // forwarding registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      uc_en   <= 1'b0;
      uc_mask <= 3'h0;
      mc_en   <= 1'b0;
      mc_mask <= 3'h0;
      vl_en   <= 1'b0;
      vl_mask <= 3'h0;
    end else if (wr) begin
      unique case (addr)
        `UFMC_OFS_UCAST: begin
          uc_en   <= wdata[`UFMC_FWD_EN_BIT];
          uc_mask <= wdata[`UFMC_FWD_MASK_HI:0];
        end
        `UFMC_OFS_MCAST: begin
          mc_en   <= wdata[`UFMC_FWD_EN_BIT];
          mc_mask <= wdata[`UFMC_FWD_MASK_HI:0];
        end
        `UFMC_OFS_VLAN: begin
          vl_en   <= wdata[`UFMC_FWD_EN_BIT];
          vl_mask <= wdata[`UFMC_FWD_MASK_HI:0];
        end
        default: begin
        end
      endcase
    end
  end

  // mac policy registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mac0 <= `UFMC_MAC0_RESET;
      mac1 <= `UFMC_MAC1_RESET;
    end else if (wr && addr == `UFMC_OFS_MAC0) begin
      mac0 <= wdata[7:0];
    end else if (wr && addr == `UFMC_OFS_MAC1) begin
      mac1 <= {4'h0, wdata[`UFMC_MAC1_NO_XCOL], 3'h0};
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (addr)
      `UFMC_OFS_UCAST:  next_rdata = fwd_word(uc_en, uc_mask);
      `UFMC_OFS_MCAST:  next_rdata = fwd_word(mc_en, mc_mask);
      `UFMC_OFS_VLAN:   next_rdata = fwd_word(vl_en, vl_mask);
      `UFMC_OFS_MAC0:   next_rdata = {24'h000000, mac0};
      `UFMC_OFS_MAC1:   next_rdata = {24'h000000, mac1};
      `UFMC_OFS_STATUS: next_rdata = {25'h0000000, fwd_rsp.ports,
                                      fwd_rsp.cls};
      default:          next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // class ranking and egress mask
  always_comb begin
    next_fwd.valid = fwd_req.valid;
    next_fwd.cls   = UFMC_CLS_NONE;
    next_fwd.ports = 3'h0;
    if (fwd_req.unk_vid) begin
      next_fwd.cls   = UFMC_CLS_VID;
      next_fwd.ports = gate_mask(vl_en, vl_mask);
    end else if (fwd_req.unk_ucast) begin
      next_fwd.cls   = UFMC_CLS_UCAST;
      next_fwd.ports = gate_mask(uc_en, uc_mask);
    end else if (fwd_req.unk_mcast) begin
      next_fwd.cls   = UFMC_CLS_MCAST;
      next_fwd.ports = gate_mask(mc_en, mc_mask);
    end
  end

  // decision sampled once, later writes do not touch it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fwd_rsp <= '{valid: 1'b0, cls: UFMC_CLS_NONE, ports: 3'h0};
    end else if (fwd_req.valid) begin
      fwd_rsp <= next_fwd;
    end else begin
      fwd_rsp.valid <= 1'b0;
    end
  end

  // receive filter
  assign fc_type = rx_req.type_len == `UFMC_FC_TYPE;
  assign fc_da   = rx_req.dest == `UFMC_FC_DA;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_rsp <= '{valid: 1'b0, drop_len: 1'b0, drop_fc: 1'b0};
    end else begin
      rx_rsp.valid    <= rx_req.valid;
      rx_rsp.drop_len <= rx_req.valid && mac0[`UFMC_MAC0_LEN_CHK] &&
                         rx_req.type_len < `UFMC_LEN_LIMIT &&
                         rx_req.length != rx_req.type_len;
      rx_rsp.drop_fc  <= rx_req.valid &&
                         (mac0[`UFMC_MAC0_FC_DROP] ?
                          (fc_type || fc_da) :
                          (fc_type && fc_da));
    end
  end

  // half-duplex back-off steering and collision drop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alt_backoff  <= 3'h0;
      aggr_backoff <= 3'h0;
    end else begin
      alt_backoff  <= half_duplex &
                      {3{mac0[`UFMC_MAC0_ALT_BO]}};
      aggr_backoff <= half_duplex &
                      {3{mac0[`UFMC_MAC0_AGGR_BO]}};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      coll_drop <= 1'b0;
    end else begin
      coll_drop <= coll.valid && coll.count >= `UFMC_XCOL_LIMIT &&
                   !mac1[`UFMC_MAC1_NO_XCOL];
    end
  end

  // checks
  mcast_fwd_a: assert property (
    fwd_req.valid && fwd_req.unk_mcast && !fwd_req.unk_vid &&
    !fwd_req.unk_ucast |=> fwd_rsp.valid &&
    fwd_rsp.cls == UFMC_CLS_MCAST &&
    fwd_rsp.ports == ($past(mc_en) ? $past(mc_mask) : 3'h0))
    else $error("unknown multicast ports wrong");

  mcast_mask_a: assert property (
    wr && addr == `UFMC_OFS_MCAST ##1 fwd_req.valid &&
    fwd_req.unk_mcast && !fwd_req.unk_vid && !fwd_req.unk_ucast
    |=> fwd_rsp.ports == ($past(wdata[31], 2) ?
                          $past(wdata[2:0], 2) : 3'h0))
    else $error("written multicast mask not applied");

  vid_fwd_a: assert property (
    fwd_req.valid && fwd_req.unk_vid && !vl_en
    |=> fwd_rsp.ports == 3'h0)
    else $error("disabled vlan forwarding leaked");

  vid_mask_a: assert property (
    fwd_req.valid && fwd_req.unk_vid && vl_en
    |=> fwd_rsp.ports == $past(vl_mask))
    else $error("vlan mask not applied");

  class_rank_a: assert property (
    fwd_req.valid && fwd_req.unk_vid
    |=> fwd_rsp.cls == UFMC_CLS_VID)
    else $error("class precedence wrong");

  ucast_rank_a: assert property (
    fwd_req.valid && !fwd_req.unk_vid && fwd_req.unk_ucast
    |=> fwd_rsp.cls == UFMC_CLS_UCAST &&
    fwd_rsp.ports == ($past(uc_en) ? $past(uc_mask) : 3'h0))
    else $error("unicast class rank wrong");

  mcast_off_a: assert property (
    fwd_req.valid && fwd_req.unk_mcast && !fwd_req.unk_vid &&
    !fwd_req.unk_ucast && !mc_en |=> fwd_rsp.ports == 3'h0)
    else $error("disabled multicast forwarding leaked");

  alt_bo_a: assert property (
    !half_duplex[0] |=> !alt_backoff[0])
    else $error("alternate back-off on full duplex");

  alt_on_a: assert property (
    half_duplex[1] && mac0[7] |=> alt_backoff[1])
    else $error("alternate back-off missing");

  len_chk_a: assert property (
    rx_req.valid && mac0[3] && rx_req.type_len < `UFMC_LEN_LIMIT &&
    rx_req.length != rx_req.type_len |=> rx_rsp.drop_len)
    else $error("length mismatch not dropped");

  len_ok_a: assert property (
    rx_req.type_len >= `UFMC_LEN_LIMIT |=> !rx_rsp.drop_len)
    else $error("long type field checked for length");

  len_skip_a: assert property (
    !mac0[3] |=> !rx_rsp.drop_len)
    else $error("length check ran while off");

  fc_or_a: assert property (
    rx_req.valid && mac0[1] && (fc_type || fc_da) |=> rx_rsp.drop_fc)
    else $error("flow control frame kept in or mode");

  fc_and_a: assert property (
    rx_req.valid && !mac0[1] && !(fc_type && fc_da)
    |=> !rx_rsp.drop_fc)
    else $error("frame dropped in and mode");

  fc_both_a: assert property (
    rx_req.valid && !mac0[1] && rx_req.type_len == `UFMC_FC_TYPE &&
    rx_req.dest == `UFMC_FC_DA |=> rx_rsp.drop_fc)
    else $error("pause frame kept in and mode");

  aggr_bo_a: assert property (
    half_duplex[2] && mac0[0] |=> aggr_backoff[2])
    else $error("aggressive back-off missing");

  aggr_off_a: assert property (
    !mac0[0] |=> aggr_backoff == 3'h0)
    else $error("aggressive back-off while disabled");

  coll_drop_a: assert property (
    coll.valid && coll.count == 5'h0F |=> !coll_drop)
    else $error("drop before sixteen collisions");

  xcol_drop_a: assert property (
    coll.valid && coll.count >= 5'h10 && !mac1[3]
    |=> coll_drop)
    else $error("excessive collision frame kept");

  xcol_keep_a: assert property (
    mac1[3] |=> !coll_drop)
    else $error("frame dropped with no-drop option");

  late_write_a: assert property (
    fwd_req.valid && fwd_req.unk_mcast && !fwd_req.unk_vid &&
    !fwd_req.unk_ucast && wr && addr == `UFMC_OFS_MCAST
    |=> fwd_rsp.ports == ($past(mc_en) ? $past(mc_mask) : 3'h0))
    else $error("write disturbed decision in flight");

endmodule

`default_nettype wire

/* tb/ufmc_policy_bench.sv */
// self-checking bench for the policy register bank
`timescale 1ns/100ps
`default_nettype none
`include "ufmc_consts.svh"

module ufmc_policy_bench
  import ufmc_pkg::*;
;
  logic                    clock;
  logic                    arst_n;
  logic [`UFMC_ADDR_W-1:0] addr;
  logic [31:0]             wdata;
  logic                    wr;
  logic                    rd;
  logic [31:0]             rdata;
  ufmc_fwd_req_t           fwd_req;
  ufmc_fwd_rsp_t           fwd_rsp;
  ufmc_rx_req_t            rx_req;
  ufmc_rx_rsp_t            rx_rsp;
  logic [2:0]              half_duplex;
  ufmc_coll_t              coll;
  logic [2:0]              alt_backoff;
  logic [2:0]              aggr_backoff;
  logic                    coll_drop;
  int                      failures;
  int                      n_tests;
  int                      cycles;

  ufmc_policy ufmc_policy_inst (
    .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .fwd_req(fwd_req),
    .fwd_rsp(fwd_rsp), .rx_req(rx_req), .rx_rsp(rx_rsp),
    .half_duplex(half_duplex), .coll(coll), .alt_backoff(alt_backoff),
    .aggr_backoff(aggr_backoff), .coll_drop(coll_drop)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // request one forward decision; expect {cls, ports}
  task automatic fwd(input logic [2:0] k, input logic [6:0] exp);
    @(posedge clock);
    fwd_req <= {1'b1, k};
    @(posedge clock);
    fwd_req <= '0;
    #1 check(32'(fwd_rsp), {24'h0, 1'b1, exp});
  endtask

  // one receive check; expect {drop_len, drop_fc}
  task automatic rx(input logic [15:0] t, input logic [47:0] d,
                    input logic [15:0] l, input logic [1:0] exp);
    @(posedge clock);
    rx_req <= {1'b1, t, d, l};
    @(posedge clock);
    rx_req <= '0;
    #1 check(32'(rx_rsp), {29'h0, 1'b1, exp});
  endtask

  task automatic coll_chk(input logic [4:0] n, input logic exp);
    @(posedge clock);
    coll <= {1'b1, n};
    @(posedge clock);
    coll <= '0;
    #1 check(32'(coll_drop), 32'(exp));
  endtask

  initial begin
    failures = 0;
    n_tests = 0;
    cycles = 0;
    arst_n = 1'b0;
    {addr, wdata, wr, rd, fwd_req, rx_req, half_duplex, coll} = '0;
    repeat (8) @(posedge clock);
    check(32'(fwd_rsp), 32'h08);
    arst_n <= 1'b1;
    rd_chk(`UFMC_OFS_MCAST, 32'h0);
    rd_chk(`UFMC_OFS_VLAN, 32'h0);
    rd_chk(`UFMC_OFS_MAC0, 32'h0E);
    rd_chk(`UFMC_OFS_MAC1, 32'h0);
    rd_chk(12'h33C, 32'h0);
    $display("test reset done");
    wr_reg(`UFMC_OFS_MCAST, 32'hFFFFFFFA);
    rd_chk(`UFMC_OFS_MCAST, 32'h80000002);
    fwd(3'b001, 7'b1000_010);
    wr_reg(`UFMC_OFS_MCAST, 32'h80000005);
    fwd(3'b001, 7'b1000_101);
    // write in the same cycle as a decision: old setting applies
    @(posedge clock);
    fwd_req <= 4'b1001;
    addr <= `UFMC_OFS_MCAST;
    wdata <= 32'h00000007;
    wr <= 1'b1;
    @(posedge clock);
    fwd_req <= '0;
    wr <= 1'b0;
    #1 check(32'(fwd_rsp), 32'hC5);
    fwd(3'b001, 7'b1000_000);
    // decision in the cycle right after a write: new setting applies
    @(posedge clock);
    addr <= `UFMC_OFS_MCAST;
    wdata <= 32'h80000003;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    fwd_req <= 4'b1001;
    @(posedge clock);
    fwd_req <= '0;
    #1 check(32'(fwd_rsp), 32'hC3);
    $display("test multicast done");
    wr_reg(`UFMC_OFS_VLAN, 32'h80000003);
    wr_reg(`UFMC_OFS_UCAST, 32'h80000006);
    rd_chk(`UFMC_OFS_UCAST, 32'h80000006);
    fwd(3'b111, 7'b0010_011);
    fwd(3'b011, 7'b0100_110);
    rd_chk(`UFMC_OFS_STATUS, 32'h64);
    wr_reg(`UFMC_OFS_VLAN, 32'h00000004);
    fwd(3'b100, 7'b0010_000);
    $display("test vlan done");
    rx(16'h8808, 48'h0, 16'h0600, 2'b01);
    rx(16'h0600, `UFMC_FC_DA, 16'h0600, 2'b01);
    rx(16'h0064, 48'h0, 16'h0063, 2'b10);
    rx(16'h05DC, 48'h0, 16'h0003, 2'b00);
    rx(16'h05DB, 48'h0, 16'h05DB, 2'b00);
    wr_reg(`UFMC_OFS_MAC0, 32'h00000000);
    rx(16'h0064, 48'h0, 16'h0063, 2'b00);
    rx(16'h8808, 48'h0, 16'h0600, 2'b00);
    rx(16'h8808, `UFMC_FC_DA, 16'h0600, 2'b01);
    $display("test receive done");
    @(posedge clock);
    half_duplex <= 3'b101;
    wr_reg(`UFMC_OFS_MAC0, 32'h00000081);
    repeat (2) @(posedge clock);
    #1 check(32'(alt_backoff), 32'h5);
    check(32'(aggr_backoff), 32'h5);
    @(posedge clock);
    half_duplex <= 3'b010;
    wr_reg(`UFMC_OFS_MAC0, 32'h00000080);
    repeat (2) @(posedge clock);
    #1 check(32'({alt_backoff, aggr_backoff}), 32'h10);
    $display("test backoff done");
    coll_chk(5'h10, 1'b1);
    coll_chk(5'h0F, 1'b0);
    wr_reg(`UFMC_OFS_MAC1, 32'h00000008);
    rd_chk(`UFMC_OFS_MAC1, 32'h08);
    coll_chk(5'h10, 1'b0);
    $display("test collision done");
    give_verdict();
  end
endmodule
`default_nettype wire
